// ==== rtl/mfe_front_end.sv ====
`timescale 1ns/1ns
`include "mfe_consts.svh"
module mfe_front_end #(
  parameter int HW = 8,
  parameter int HDEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic stStateChange,
  input wire mfe_pkg::mfe_mode_t stMode,
  input wire logic [31:0] stDescBase,
  input wire logic [31:0] stScratchBase,
  input wire logic [3:0] stScratchCfg,
  output logic hmAllocReq,
  input wire logic hmAllocVld,
  input wire logic [HW-1:0] hmAllocHandle,
  input wire logic cmdStart,
  input wire logic [5:0] cmdDescOffset,
  input wire logic [7:0] cmdInlineDw,
  input wire logic [7:0] cmdIndirectCnt,
  input wire logic [5:0] cmdCbp,
  input wire logic [HW-1:0] cmdConstHandle,
  output logic cmdReady,
  input wire logic cmdDataVld,
  input wire logic [31:0] cmdData,
  input wire logic [255:0] cmdWideData,
  output logic cmdDataRdy,
  output logic urbWrEn,
  output logic [HW-1:0] urbHandle,
  output logic [7:0] urbRow,
  output logic [255:0] urbData,
  output logic vldDataVld,
  output logic [31:0] vldData,
  output logic tsSpawn,
  output logic [31:0] tsDescPtr,
  output logic [HW-1:0] tsHandle,
  output logic [HW-1:0] tsConstHandle,
  output logic [31:0] tsScratchBase,
  output logic [3:0] tsScratchCfg,
  output logic [7:0] tsMsgRows,
  input wire logic tsRelease,
  input wire logic [HW-1:0] tsRelHandle
);
  import mfe_pkg::*;
  localparam int HIW = $clog2(HDEPTH);

  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + 4'(v[i]);
    end
    return n;
  endfunction : ones8

  // rows of 8 dwords; uncoded blocks add nothing
  function automatic logic [7:0] msgRows(input mfe_mode_t m, input logic [7:0] inl,
    input logic [7:0] ind, input logic [5:0] cbp);
    logic [7:0] r;
    r = 8'((9'(inl) + 9'h007) >> 3);
    case (m)
      MODE_GENERIC: r = r + ind;
      MODE_INV_SCAN: r = r + {2'h0, ones8({2'h0, cbp}), 2'h0};
      default: r = r;
    endcase
    return r;
  endfunction : msgRows

  mfe_state_t fsm_q, fsm_d;
  mfe_mode_t mode_q;
  logic stLatched_q;
  logic [31:0] descBase_q, scratchBase_q, ctrl_q, thrdCnt_q;
  logic [3:0] scratchCfg_q;
  logic [HW-1:0] hBuf_q [HDEPTH];
  logic [HDEPTH-1:0] hFree_q;
  logic [HIW-1:0] head_q, fillIdx_q;
  logic [5:0] descOfs_q, cbp_q;
  logic [7:0] inlineDw_q, indCnt_q, inlineLeft_q, indLeft_q, wrRow_q;
  logic [HW-1:0] curHandle_q, constHandle_q;
  logic [255:0] rowBuf_q, rowNext;
  logic [2:0] dwIdx_q;
  logic cmdTake, dataTake, inlineLast, indLast, eobTake, rowFull;
  logic isCoefVld, isBusy, isRowVld;
  logic [255:0] isRowData;

  // ****************************************
  // command and data handshake
  // ****************************************
  assign cmdTake = cmdStart && cmdReady;
  assign dataTake = cmdDataVld && cmdDataRdy;
  assign inlineLast = dataTake && fsm_q == ST_INLINE && inlineLeft_q == 8'h01;
  assign indLast = dataTake && fsm_q == ST_INDIRECT && indLeft_q == 8'h01;
  assign eobTake = dataTake && fsm_q == ST_INDIRECT && mode_q == MODE_INV_SCAN &&
    cmdData[`MFE_EOB_BIT];
  assign isCoefVld = dataTake && fsm_q == ST_INDIRECT && mode_q == MODE_INV_SCAN;
  assign rowFull = dwIdx_q == `MFE_ROW_DW;

  always_comb begin
    rowNext = rowBuf_q;
    rowNext[32*dwIdx_q +: 32] = cmdData;
  end

  always_comb begin
    fsm_d = fsm_q;
    case (fsm_q)
      ST_IDLE: begin
        if (stStateChange) begin
          fsm_d = ST_ALLOC;
        end else if (cmdTake) begin
          fsm_d = cmdInlineDw != 8'h00 ? ST_INLINE :
            cmdIndirectCnt != 8'h00 ? ST_INDIRECT : ST_SPAWN;
        end
      end
      ST_ALLOC: begin
        if (hmAllocVld && fillIdx_q == HIW'(HDEPTH - 1)) begin
          fsm_d = ST_IDLE;
        end
      end
      ST_INLINE: begin
        if (inlineLast) begin
          fsm_d = indLeft_q != 8'h00 ? ST_INDIRECT : ST_SPAWN;
        end
      end
      ST_INDIRECT: begin
        if (indLast) begin
          fsm_d = mode_q == MODE_INV_SCAN ? ST_DRAIN : ST_SPAWN;
        end
      end
      ST_DRAIN: begin
        // last block rows must land before the spawn
        if (!isBusy) begin
          fsm_d = ST_SPAWN;
        end
      end
      ST_SPAWN: fsm_d = ST_IDLE;
      default: fsm_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fsm_q <= ST_IDLE;
    end else begin
      fsm_q <= fsm_d;
    end
  end

  // ready is registered from the next state, so it drops right after the last transfer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdReady <= 1'b0;
      cmdDataRdy <= 1'b0;
      hmAllocReq <= 1'b0;
    end else begin
      cmdReady <= ctrl_q[`MFE_CTRL_EN] && fsm_d == ST_IDLE && !cmdTake &&
        !stStateChange && hFree_q[head_q];
      cmdDataRdy <= (fsm_d == ST_INLINE) ||
        (fsm_d == ST_INDIRECT && !eobTake && !isBusy);
      hmAllocReq <= fsm_d == ST_ALLOC && !(hmAllocVld && fsm_q == ST_ALLOC &&
        fillIdx_q == HIW'(HDEPTH - 2));
    end
  end

  // ****************************************
  // state capture at first primitive
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stLatched_q <= 1'b0;
      mode_q <= MODE_GENERIC;
      descBase_q <= 32'h0000_0000;
      scratchBase_q <= 32'h0000_0000;
      scratchCfg_q <= 4'h0;
    end else if (stStateChange) begin
      stLatched_q <= 1'b0;
    end else if (cmdTake && !stLatched_q) begin
      stLatched_q <= 1'b1;
      mode_q <= stMode;
      descBase_q <= stDescBase;
      scratchBase_q <= stScratchBase;
      scratchCfg_q <= stScratchCfg;
    end
  end

  // ****************************************
  // handle ring
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hFree_q <= '0;
      head_q <= '0;
      fillIdx_q <= '0;
      curHandle_q <= '0;
      for (int i = 0; i < HDEPTH; i++) begin
        hBuf_q[i] <= '0;
      end
    end else if (fsm_q == ST_IDLE && stStateChange) begin
      hFree_q <= '0;
      head_q <= '0;
      fillIdx_q <= '0;
    end else begin
      if (fsm_q == ST_ALLOC && hmAllocVld) begin
        hBuf_q[fillIdx_q] <= hmAllocHandle;
        hFree_q[fillIdx_q] <= 1'b1;
        fillIdx_q <= fillIdx_q + 1'b1;
      end
      if (cmdTake) begin
        curHandle_q <= hBuf_q[head_q];
        hFree_q[head_q] <= 1'b0;
        head_q <= head_q + 1'b1;
      end
      for (int i = 0; i < HDEPTH; i++) begin
        if (tsRelease && !hFree_q[i] && hBuf_q[i] == tsRelHandle) begin
          hFree_q[i] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // per-command counters
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      descOfs_q <= 6'h00;
      cbp_q <= 6'h00;
      inlineDw_q <= 8'h00;
      indCnt_q <= 8'h00;
      inlineLeft_q <= 8'h00;
      indLeft_q <= 8'h00;
      constHandle_q <= '0;
    end else if (cmdTake) begin
      descOfs_q <= cmdDescOffset;
      cbp_q <= cmdCbp;
      inlineDw_q <= cmdInlineDw;
      indCnt_q <= cmdIndirectCnt;
      inlineLeft_q <= cmdInlineDw;
      indLeft_q <= cmdIndirectCnt;
      constHandle_q <= cmdConstHandle;
    end else if (dataTake) begin
      if (fsm_q == ST_INLINE) begin
        inlineLeft_q <= inlineLeft_q - 8'h01;
      end else begin
        indLeft_q <= indLeft_q - 8'h01;
      end
    end
  end

  // ****************************************
  // payload into the return buffer
  // ****************************************
  mfe_inv_scan u_scan (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .coefVld(isCoefVld),
    .coefData(cmdData),
    .busy(isBusy),
    .rowVld(isRowVld),
    .rowData(isRowData)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rowBuf_q <= '0;
      dwIdx_q <= 3'h0;
    end else if (cmdTake) begin
      rowBuf_q <= '0;
      dwIdx_q <= 3'h0;
    end else if (dataTake && fsm_q == ST_INLINE) begin
      rowBuf_q <= (rowFull || inlineLast) ? '0 : rowNext;
      dwIdx_q <= inlineLast ? 3'h0 : dwIdx_q + 3'h1;
    end
  end

  // inline moves a dword a beat, pass-through indirect a whole row a beat
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      urbWrEn <= 1'b0;
      urbData <= '0;
      urbRow <= 8'h00;
      urbHandle <= '0;
      wrRow_q <= 8'h00;
    end else begin
      urbWrEn <= 1'b0;
      urbHandle <= curHandle_q;
      if (cmdTake) begin
        wrRow_q <= 8'h00;
      end
      if (dataTake && fsm_q == ST_INLINE && (rowFull || inlineLast)) begin
        urbWrEn <= 1'b1;
        urbData <= rowNext;
        urbRow <= wrRow_q;
        wrRow_q <= wrRow_q + 8'h01;
      end else if (dataTake && fsm_q == ST_INDIRECT && mode_q == MODE_GENERIC) begin
        urbWrEn <= 1'b1;
        urbData <= cmdWideData;
        urbRow <= wrRow_q;
        wrRow_q <= wrRow_q + 8'h01;
      end else if (isRowVld) begin
        urbWrEn <= 1'b1;
        urbData <= isRowData;
        urbRow <= wrRow_q;
        wrRow_q <= wrRow_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vldDataVld <= 1'b0;
      vldData <= 32'h0000_0000;
    end else begin
      vldDataVld <= dataTake && fsm_q == ST_INDIRECT && mode_q == MODE_VLD;
      vldData <= cmdData;
    end
  end

  // ****************************************
  // spawner hand-off
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tsSpawn <= 1'b0;
      tsDescPtr <= 32'h0000_0000;
      tsHandle <= '0;
      tsConstHandle <= '0;
      tsScratchBase <= 32'h0000_0000;
      tsScratchCfg <= 4'h0;
      tsMsgRows <= 8'h00;
    end else begin
      tsSpawn <= fsm_q == ST_SPAWN;
      if (fsm_q == ST_SPAWN) begin
        tsDescPtr <= descBase_q + (32'(descOfs_q) << `MFE_DESC_SHIFT);
        tsHandle <= curHandle_q;
        tsConstHandle <= constHandle_q;
        tsScratchBase <= scratchBase_q;
        tsScratchCfg <= scratchCfg_q;
        tsMsgRows <= msgRows(mode_q, inlineDw_q, indCnt_q, cbp_q);
      end
    end
  end

  // ****************************************
  // software port
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `MFE_CTRL_RST;
      thrdCnt_q <= 32'h0000_0000;
      regRdData <= 32'h0000_0000;
    end else begin
      if (regWr && regAddr == `MFE_REG_CTRL) begin
        ctrl_q <= {31'h0, regWrData[`MFE_CTRL_EN]};
      end
      if (fsm_q == ST_SPAWN) begin
        thrdCnt_q <= thrdCnt_q + 32'h0000_0001;
      end
      regRdData <= 32'h0000_0000;
      if (regRd) begin
        case (regAddr)
          `MFE_REG_CTRL: regRdData <= ctrl_q;
          `MFE_REG_STAT: regRdData <= {17'h0, 4'(head_q), ones8(8'(hFree_q)), 1'b0,
            fsm_q, mode_q, stLatched_q};
          `MFE_REG_THRD: regRdData <= thrdCnt_q;
          default: regRdData <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_spawn_after_data: assert property (tsSpawn |-> !urbWrEn && !isBusy && $past(fsm_q) == ST_SPAWN)
    else $error("spawn overlaps payload write");
  a_desc_ptr_math: assert property (tsSpawn |-> tsDescPtr == $past(descBase_q) + ($past(32'(descOfs_q)) << 5))
    else $error("descriptor pointer wrong");
  a_const_passthru: assert property (tsSpawn |-> tsConstHandle == $past(constHandle_q))
    else $error("constant handle altered");
  a_head_in_order: assert property (cmdTake && !stStateChange |=> head_q == $past(head_q) + 1'b1 && !hFree_q[$past(head_q)])
    else $error("handle not taken from head");
  a_stall_no_handle: assert property (cmdReady |-> hFree_q[head_q])
    else $error("ready without free handle");
  a_free_cause: assert property ($rose(hFree_q[0]) |-> $past(tsRelease || fsm_q == ST_ALLOC))
    else $error("handle freed without release");
  a_latch_first: assert property ($rose(stLatched_q) |-> $past(cmdTake))
    else $error("state latched without primitive");
  a_is_size: assert property (tsSpawn && mode_q == MODE_INV_SCAN |->
    tsMsgRows == 8'((9'(inlineDw_q) + 9'h007) >> 3) + 8'(4 * $countones(cbp_q)))
    else $error("scan message size wrong");
  a_one_dword: assert property (vldDataVld |-> $past(dataTake) && $past(mode_q) == MODE_VLD)
    else $error("decode dword without transfer");
  a_alloc_on_change: assert property (fsm_q == ST_IDLE && stStateChange |=> fsm_q == ST_ALLOC ##1 hmAllocReq)
    else $error("no allocation after state change");

  c_generic_thread: cover property (tsSpawn && mode_q == MODE_GENERIC);
  c_scan_thread: cover property (tsSpawn && mode_q == MODE_INV_SCAN && cbp_q != 6'h00);
  c_stall_empty: cover property (fsm_q == ST_IDLE && !hFree_q[head_q] && ctrl_q[0]);
  c_release: cover property (tsRelease ##1 cmdReady);
endmodule : mfe_front_end

// ==== shared/mfe_consts.svh ====
`ifndef MFE_CONSTS_SVH
`define MFE_CONSTS_SVH
// Functional notes
// - never talk to the dispatcher; hand descriptor pointer of a ready thread to spawner
// - inverse-scan and decode modes take one dword per transfer, routed to active stage
// - pass-through mode pushes indirect data a full row per beat, inline a dword
// - descriptor pointer and handle go to spawner only after full payload write
// - constant-buffer handle from the streamer goes to the spawner unchanged
// - scratch configuration from state goes out with every descriptor pointer
// - state variables are latched only when the first primitive command arrives
// - every state change allocates the root-thread handles from the handle manager; the code allocates only on a change seen while idle
// - handles sit in a circular buffer, taken in order, released in any order
// - each root thread uses exactly one handle, forwarded to the spawner
// - the handle holds the payload first, later the root thread return space
// - a handle is freed only on the spawner release, then reusable
// - pass-through makes one thread per command, streaming inline and indirect payload
// - descriptor pointer is base plus offset times fixed descriptor size
// - spawner is told to start only after the thread data is written
// - inverse-scan mode makes one thread per macroblock command
// - coefficients placed by (x,y) in a zeroed 8x8 block, then block written
// - uncoded blocks omitted, coded packed, size derived from coded block pattern
// - inverse-scan inline data goes straight to the buffer, indirect through scan logic
// - one mode set by the state, changed only by a state change
`define MFE_REG_CTRL 4'h0
`define MFE_REG_STAT 4'h4
`define MFE_REG_THRD 4'h8
`define MFE_CTRL_EN 0
`define MFE_CTRL_RST 32'h0000_0001
`define MFE_DESC_SHIFT 5
`define MFE_ROW_DW 3'h7
`define MFE_BLK_ROWS 4
`define MFE_EOB_BIT 31
`define MFE_X_LSB 16
`define MFE_Y_LSB 19
`endif

// ==== shared/mfe_pkg.sv ====
package mfe_pkg;
  typedef enum logic [1:0] {MODE_GENERIC, MODE_INV_SCAN, MODE_VLD} mfe_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ALLOC, ST_INLINE, ST_INDIRECT, ST_DRAIN,
    ST_SPAWN} mfe_state_t;
endpackage : mfe_pkg

// ==== rtl/mfe_inv_scan.sv ====
`timescale 1ns/1ns
`include "mfe_consts.svh"
module mfe_inv_scan (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic coefVld,
  input wire logic [31:0] coefData,
  output logic busy,
  output logic rowVld,
  output logic [255:0] rowData
);
  import mfe_pkg::*;
  logic [15:0] coef_q [64];
  logic [1:0] rowIdx_q;
  logic busy_q;
  logic [5:0] pos;

  assign pos = {coefData[`MFE_Y_LSB +: 3], coefData[`MFE_X_LSB +: 3]};
  assign busy = busy_q;
  assign rowVld = busy_q;

  // ****************************************
  // block storage, zeroed after each flush
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 64; i++) begin
        coef_q[i] <= 16'h0000;
      end
    end else if (busy_q && rowIdx_q == 2'(`MFE_BLK_ROWS - 1)) begin
      for (int i = 0; i < 64; i++) begin
        coef_q[i] <= 16'h0000;
      end
    end else if (coefVld) begin
      coef_q[pos] <= coefData[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      rowIdx_q <= 2'h0;
    end else if (busy_q) begin
      rowIdx_q <= rowIdx_q + 2'h1;
      busy_q <= rowIdx_q != 2'(`MFE_BLK_ROWS - 1);
    end else if (coefVld && coefData[`MFE_EOB_BIT]) begin
      busy_q <= 1'b1;
      rowIdx_q <= 2'h0;
    end
  end

  // two block rows per buffer row
  for (genvar k = 0; k < 16; k++) begin : g_row
    assign rowData[16*k +: 16] = coef_q[{rowIdx_q, 4'(k)}];
  end
endmodule : mfe_inv_scan

// ==== testbench/mfe_far_side.sv ====
`timescale 1ns/1ns
module mfe_far_side (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic hmAllocReq,
  output logic hmAllocVld,
  output logic [7:0] hmAllocHandle,
  input wire logic tsSpawn,
  input wire logic [7:0] tsHandle,
  input wire logic relEn,
  output logic tsRelease,
  output logic [7:0] tsRelHandle
);
  logic [7:0] nextH;
  logic [3:0] given;
  logic [7:0] live[$];
  // ********
  // handle manager and spawner release
  // ********
  // slow manager: one handle every other cycle, eight per request
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hmAllocVld <= 1'b0;
      hmAllocHandle <= 8'h00;
      nextH <= 8'h10;
      given <= 4'h0;
    end else if (hmAllocReq && !hmAllocVld && given < 4'h8) begin
      hmAllocVld <= 1'b1;
      hmAllocHandle <= nextH;
      nextH <= nextH + 8'h01;
      given <= given + 4'h1;
    end else begin
      hmAllocVld <= 1'b0;
      hmAllocHandle <= ~hmAllocHandle;
      if (!hmAllocReq) given <= 4'h0;
    end
  end
  // newest first, so releases come out of order
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tsRelease <= 1'b0;
      tsRelHandle <= 8'h00;
      live.delete();
    end else begin
      if (tsSpawn) live.push_back(tsHandle);
      if (relEn && !tsRelease && live.size() > 0) begin
        tsRelease <= 1'b1;
        tsRelHandle <= live.pop_back();
      end else begin
        tsRelease <= 1'b0;
        tsRelHandle <= ~tsRelHandle;
      end
    end
  end
endmodule : mfe_far_side

// ==== testbench/mfe_front_end_bench.sv ====
`timescale 1ns/1ns
`include "mfe_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module mfe_front_end_bench;
  import mfe_pkg::*;
  logic ref_clk, rst_b, regWr, regRd, stStateChange, hmAllocVld, hmAllocReq, cmdStart;
  logic cmdReady, cmdDataVld, cmdDataRdy, urbWrEn, vldDataVld, tsSpawn, tsRelease, relEn;
  logic exactH;
  logic [3:0] regAddr, stScratchCfg, tsScratchCfg;
  logic [5:0] cmdDescOffset, cmdCbp;
  logic [7:0] cmdInlineDw, cmdIndirectCnt, urbRow, tsMsgRows, hBase, curH;
  logic [7:0] hmAllocHandle, cmdConstHandle, urbHandle, tsHandle, tsConstHandle, tsRelHandle;
  logic [31:0] regWrData, regRdData, stDescBase, stScratchBase, cmdData, vldData, lastVld;
  logic [31:0] tsDescPtr, tsScratchBase;
  logic [255:0] cmdWideData, urbData;
  mfe_mode_t stMode;
  logic [31:0] dArr [0:10];
  logic [255:0] wArr [0:1];
  logic [255:0] rowMem [0:15];
  int checks, n_mismatch, cyc, nRows, spawnRows, nVld, slot;

  mfe_front_end mfe_front_end_i (.ref_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .stStateChange, .stMode, .stDescBase, .stScratchBase, .stScratchCfg,
    .hmAllocReq, .hmAllocVld, .hmAllocHandle, .cmdStart, .cmdDescOffset, .cmdInlineDw,
    .cmdIndirectCnt, .cmdCbp, .cmdConstHandle, .cmdReady, .cmdDataVld, .cmdData,
    .cmdWideData, .cmdDataRdy, .urbWrEn, .urbHandle, .urbRow, .urbData, .vldDataVld,
    .vldData, .tsSpawn, .tsDescPtr, .tsHandle, .tsConstHandle, .tsScratchBase,
    .tsScratchCfg, .tsMsgRows, .tsRelease, .tsRelHandle);
  mfe_far_side mfe_far_side_i (.ref_clk, .rst_b, .hmAllocReq, .hmAllocVld, .hmAllocHandle,
    .tsSpawn, .tsHandle, .relEn, .tsRelease, .tsRelHandle);

  // ********
  // bus tasks and monitor
  // ********
  always #20 ref_clk = ~ref_clk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  always @(posedge ref_clk) begin
    cyc++;
    if (urbWrEn) begin
      rowMem[urbRow[3:0]] <= urbData;
      nRows <= nRows + 1;
      `CHK("urbHandle", curH, urbHandle)
    end
    if (vldDataVld) begin
      nVld <= nVld + 1;
      lastVld <= vldData;
    end
    if (tsSpawn) spawnRows <= nRows;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic regW(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : regW

  task automatic regR(input logic [3:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    `CHK("regRdData", e, regRdData)
    @(posedge ref_clk);
  endtask : regR

  task automatic stateChg(input logic [7:0] b);
    stStateChange <= 1'b1;
    @(posedge ref_clk);
    stStateChange <= 1'b0;
    hBase = b;
    slot = 0;
    do @(negedge ref_clk); while (hmAllocReq !== 1'b1);
    do @(negedge ref_clk); while (hmAllocReq !== 1'b0);
    repeat (3) @(posedge ref_clk);
  endtask : stateChg

  task automatic chkRow0;
    for (int k = 0; k < 8; k++) `CHK("inlineRow0", dArr[k], rowMem[0][32*k+:32])
  endtask : chkRow0

  // a stalled command checks that ready stays low for 20 cycles before any handle is released
  task automatic runCmd(input logic stall, input logic [5:0] off, input logic [7:0] inl,
      input logic [7:0] ind, input logic [5:0] cbp, input logic [7:0] rows);
    int r0;
    r0 = nRows;
    curH = hBase + {5'h00, slot[2:0]};
    cmdDescOffset <= off;
    cmdInlineDw <= inl;
    cmdIndirectCnt <= ind;
    cmdCbp <= cbp;
    cmdConstHandle <= 8'hC3 ^ {2'h0, off};
    cmdStart <= 1'b1;
    if (stall) begin
      repeat (20) begin
        @(negedge ref_clk);
        `CHK("stallReady", 1'b0, cmdReady)
      end
      @(posedge ref_clk);
      relEn <= 1'b1;
    end
    do @(negedge ref_clk); while (cmdReady !== 1'b1);
    @(posedge ref_clk);
    cmdStart <= 1'b0;
    for (int j = 0; j < inl + ind; j++) begin
      cmdDataVld <= 1'b1;
      cmdData <= dArr[j];
      cmdWideData <= wArr[(j - inl) & 1];
      do @(negedge ref_clk); while (cmdDataRdy !== 1'b1);
      @(posedge ref_clk);
    end
    cmdDataVld <= 1'b0;
    do @(negedge ref_clk); while (tsSpawn !== 1'b1);
    `CHK("tsDescPtr", stDescBase + {21'h0, off, 5'h00}, tsDescPtr)
    `CHK("tsConstHandle", 8'hC3 ^ {2'h0, off}, tsConstHandle)
    `CHK("tsScratchBase", stScratchBase, tsScratchBase)
    `CHK("tsScratchCfg", stScratchCfg, tsScratchCfg)
    `CHK("tsMsgRows", rows, tsMsgRows)
    if (exactH) `CHK("tsHandle", curH, tsHandle)
    else `CHK("tsHandleSet", curH[7:3], tsHandle[7:3])
    repeat (3) @(posedge ref_clk);
    `CHK("rowsBeforeSpawn", rows, spawnRows - r0)
    `CHK("rowsAfterSpawn", rows, nRows - r0)
    slot++;
  endtask : runCmd

  // ********
  // main sequence
  // ********
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    {regWr, regRd, stStateChange, cmdStart, cmdDataVld, relEn} = 6'h00;
    exactH = 1'b1;
    regAddr = 4'h0;
    regWrData = 32'h0;
    stMode = MODE_GENERIC;
    stDescBase = 32'h0000_1000;
    stScratchBase = 32'hABCD_0040;
    stScratchCfg = 4'h5;
    {cmdDescOffset, cmdCbp, cmdInlineDw, cmdIndirectCnt, cmdConstHandle} = 36'h0;
    cmdData = 32'h0;
    cmdWideData = 256'h0;
    for (int i = 0; i < 11; i++) dArr[i] = 32'hD000_0000 + i;
    dArr[8] = 32'h0001_1234;
    dArr[9] = 32'h803F_8001;
    dArr[10] = 32'h8010_0055;
    wArr[0] = {8{32'hA5A5_0F0F}};
    wArr[1] = {8{32'h1234_5678}};
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    regR(`MFE_REG_CTRL, 32'h0000_0001);
    regR(`MFE_REG_STAT, 32'h0000_0000);
    regW(`MFE_REG_THRD, 32'h0000_005A);
    regR(`MFE_REG_THRD, 32'h0000_0000);
    regR(4'hC, 32'h0000_0000);
    @(negedge ref_clk);
    `CHK("readyNoHandles", 1'b0, cmdReady)
    `CHK("allocNoChange", 1'b0, hmAllocReq)
    @(posedge ref_clk);
    stateChg(8'h10);
    regR(`MFE_REG_STAT, 32'h0000_0400);
    regW(`MFE_REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("readyDisabled", 1'b0, cmdReady)
    @(posedge ref_clk);
    regW(`MFE_REG_CTRL, 32'h0000_0001);
    runCmd(1'b0, 6'h3F, 8'h09, 8'h02, 6'h00, 8'h04);
    chkRow0();
    `CHK("inlineRow1", {224'h0, dArr[8]}, rowMem[1])
    `CHK("wideRow2", wArr[0], rowMem[2])
    `CHK("wideRow3", wArr[1], rowMem[3])
    repeat (7) runCmd(1'b0, 6'h01, 8'h00, 8'h00, 6'h00, 8'h00);
    runCmd(1'b1, 6'h02, 8'h00, 8'h00, 6'h00, 8'h00);
    repeat (7) runCmd(1'b0, 6'h03, 8'h00, 8'h00, 6'h00, 8'h00);
    repeat (30) @(posedge ref_clk);
    regR(`MFE_REG_THRD, 32'h0000_0010);
    stateChg(8'h18);
    stMode <= MODE_INV_SCAN;
    stDescBase <= 32'h0000_2000;
    stScratchBase <= 32'h0000_8000;
    stScratchCfg <= 4'hA;
    @(posedge ref_clk);
    runCmd(1'b0, 6'h05, 8'h08, 8'h03, 6'h21, 8'h09);
    chkRow0();
    `CHK("scanRow1", {224'h0, 16'h1234, 16'h0000}, rowMem[1])
    `CHK("scanRow4", {16'h8001, 240'h0}, rowMem[4])
    `CHK("scanRow5", 256'h0, rowMem[5])
    `CHK("scanRow6", {240'h0, 16'h0055}, rowMem[6])
    repeat (30) @(posedge ref_clk);
    `CHK("vldIdle", 0, nVld)
    exactH = 1'b0;
    stateChg(8'h20);
    stMode <= MODE_VLD;
    @(posedge ref_clk);
    runCmd(1'b0, 6'h00, 8'h00, 8'h03, 6'h00, 8'h00);
    `CHK("vldCount", 3, nVld)
    `CHK("vldData", dArr[2], lastVld)
    give_verdict();
  end
endmodule : mfe_front_end_bench
